// [src/blkrp_pkg.sv]
// package: register map, status layouts, reset values and types
package blkrp_pkg;

  // ****************************************
  // widths and types
  // ****************************************
  localparam int DATA_AW = 23;
  typedef logic [15:0]        blkrp_word_t;
  typedef logic [23:0]        blkrp_paddr_t;
  typedef logic [DATA_AW-1:0] blkrp_daddr_t;

  // ****************************************
  // data addresses
  // ****************************************
  localparam blkrp_daddr_t ADDR_ST0      = 23'h000002;
  localparam blkrp_daddr_t ADDR_ST1      = 23'h000003;
  localparam blkrp_daddr_t ADDR_ST3      = 23'h000004;
  localparam blkrp_daddr_t ADDR_ST0_ALT  = 23'h000006;
  localparam blkrp_daddr_t ADDR_ST1_ALT  = 23'h000007;
  localparam blkrp_daddr_t ADDR_ST3_ALT  = 23'h00001D;
  localparam blkrp_daddr_t ADDR_ST2      = 23'h00004B;
  localparam blkrp_daddr_t ADDR_OCNT     = 23'h00001A;
  localparam blkrp_daddr_t ADDR_ICNT     = 23'h000039;
  localparam blkrp_daddr_t ADDR_ISAVE    = 23'h00003A;
  localparam blkrp_daddr_t ADDR_OSTRT_HI = 23'h00003C;
  localparam blkrp_daddr_t ADDR_OSTRT_LO = 23'h00003D;
  localparam blkrp_daddr_t ADDR_OEND_HI  = 23'h00003E;
  localparam blkrp_daddr_t ADDR_OEND_LO  = 23'h00003F;
  localparam blkrp_daddr_t ADDR_ISTRT_HI = 23'h000042;
  localparam blkrp_daddr_t ADDR_ISTRT_LO = 23'h000043;
  localparam blkrp_daddr_t ADDR_IEND_HI  = 23'h000044;
  localparam blkrp_daddr_t ADDR_IEND_LO  = 23'h000045;

  // ****************************************
  // status word layouts, index 0 is word zero
  // ****************************************
  localparam int BIT_LOOP_ACTIVE  = 15;
  localparam int BIT_LEGACY_MODE  = 5;
  localparam int BIT_PROG_MEM_SEL = 6;
  localparam logic [3:0][15:0] ST_RESET =
    {16'h1C00, 16'h7000, 16'h2920, 16'h3800};
  localparam logic [3:0][15:0] ST_WR_MASK =
    {16'hFFF7, 16'h9DFF, 16'hFFFF, 16'hFFFF};
  localparam logic [3:0][15:0] ST_PROT_MASK =
    {16'hF0A0, 16'h0000, 16'h0400, 16'hE000};
  localparam blkrp_word_t ST3_CACHE_BITS = 16'hE000;

  // ****************************************
  // decoded register target, top state and level state
  // ****************************************
  typedef enum {
    REG_NONE, REG_ST0, REG_ST1, REG_ST2, REG_ST3,
    REG_ST0_ALT, REG_ST1_ALT, REG_ST3_ALT,
    REG_OCNT, REG_ICNT, REG_ISAVE,
    REG_OSTRT_HI, REG_OSTRT_LO, REG_OEND_HI, REG_OEND_LO,
    REG_ISTRT_HI, REG_ISTRT_LO, REG_IEND_HI, REG_IEND_LO
  } blkrp_reg_t;

  typedef struct packed {
    logic        outerRun;
    logic        innerRun;
    blkrp_word_t rdData;
    logic        rdValid;
  } blkrp_top_t;

  typedef struct packed {
    blkrp_word_t  count;
    blkrp_word_t  save;
    blkrp_paddr_t startAddr;
    blkrp_paddr_t endAddr;
  } blkrp_level_t;

endpackage

// [src/blkrp_level_if.sv]
// interface: control of one loop level by the top
`timescale 1ns/1ps
`default_nettype none
interface blkrp_level_if;
  logic        wrCount;
  logic        wrSave;
  logic        wrStartHi;
  logic        wrStartLo;
  logic        wrEndHi;
  logic        wrEndLo;
  logic [15:0] wrData;
  logic        launch;
  logic [23:0] launchStart;
  logic [23:0] launchEnd;
  logic        step;
  logic [15:0] count;
  logic [15:0] save;
  logic [23:0] startAddr;
  logic [23:0] endAddr;
  modport ctrl (
    output wrCount, wrSave, wrStartHi, wrStartLo, wrEndHi, wrEndLo,
    output wrData, launch, launchStart, launchEnd, step,
    input  count, save, startAddr, endAddr
  );
  modport level (
    input  wrCount, wrSave, wrStartHi, wrStartLo, wrEndHi, wrEndLo,
    input  wrData, launch, launchStart, launchEnd, step,
    output count, save, startAddr, endAddr
  );
endinterface
`default_nettype wire

// [src/blkrp_loop_level.sv]
// module: counter, start, end and optional save register of one level
`timescale 1ns/1ps
`default_nettype none
module blkrp_loop_level #(
  parameter bit SAVE_PRESENT = 1'b0
) (
  input  wire logic   clk_sys,
  input  wire logic   srst,
  input  wire logic   clkEn,
  blkrp_level_if.level lv
);
  import blkrp_pkg::*;

  blkrp_level_t s_q;
  blkrp_level_t s_d;

  always_comb begin
    s_d = s_q;
    if (lv.launch) begin
      s_d.startAddr = lv.launchStart;
      s_d.endAddr   = lv.launchEnd;
      if (SAVE_PRESENT) begin
        s_d.count = s_q.save; // see RULE6
      end
    end else if (lv.step) begin
      s_d.count = s_q.count - 16'h0001; // see RULE19
    end
    if (lv.wrStartHi) s_d.startAddr[23:16] = lv.wrData[7:0]; // see RULE9
    if (lv.wrStartLo) s_d.startAddr[15:0]  = lv.wrData;
    if (lv.wrEndHi)   s_d.endAddr[23:16]   = lv.wrData[7:0];
    if (lv.wrEndLo)   s_d.endAddr[15:0]    = lv.wrData;
    if (lv.wrCount) begin
      s_d.count = lv.wrData; // see RULE1
      if (SAVE_PRESENT) begin
        s_d.save = lv.wrData; // see RULE4
      end
    end
    if (lv.wrSave && SAVE_PRESENT) begin
      s_d.save = lv.wrData; // see RULE5
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  assign lv.count     = s_q.count;
  assign lv.save      = s_q.save;
  assign lv.startAddr = s_q.startAddr;
  assign lv.endAddr   = s_q.endAddr;
endmodule
`default_nettype wire

// [src/blkrp_status_word.sv]
// module: one status word with full and protected write paths
`timescale 1ns/1ps
`default_nettype none
module blkrp_status_word #(
  parameter logic [15:0] WR_MASK   = 16'hFFFF,
  parameter logic [15:0] PROT_MASK = 16'h0000
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        clkEn,
  input  wire logic        fullWr,
  input  wire logic        aliasWr,
  input  wire logic [15:0] wrData,
  input  wire logic [15:0] hwSet,
  input  wire logic [15:0] hwClr,
  input  wire logic [15:0] resetVal,
  output logic      [15:0] value
);
  import blkrp_pkg::*;

  blkrp_word_t w_q;
  blkrp_word_t w_d;
  blkrp_word_t keep;

  always_comb begin
    keep = ~WR_MASK;
    w_d  = w_q;
    if (fullWr) begin
      w_d = (w_q & keep) | (wrData & ~keep); // see RULE12
    end else if (aliasWr) begin
      keep = ~WR_MASK | PROT_MASK; // see RULE13
      w_d  = (w_q & keep) | (wrData & ~keep);
    end
    w_d = (w_d & ~hwClr) | hwSet;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      w_q <= resetVal; // see RULE20
    end else if (clkEn) begin
      w_q <= w_d;
    end
  end

  assign value = w_q;
endmodule
`default_nettype wire

// [src/blkrp_regs.sv]
// top: block-repeat loop registers and the four status words
//
// Function
// (RULE1) outer and inner counters are 16 bits
// (RULE2) each level has 24-bit start address
// (RULE3) each level has 24-bit end address
// (RULE4) loading inner counter also loads save copy
// (RULE5) save copy unchanged while inner loop counts
// (RULE6) inner start reloads counter from save copy
// (RULE7) legacy mode uses outer level only
// (RULE8) program avoids counter writes near loop end
// (RULE9) 24-bit address split high byte, low word
// (RULE10) outer start at 3Ch high, 3Dh low
// (RULE11) four 16-bit status words
// (RULE12) words zero, one, three have alias
// (RULE13) alias writes leave protected bits alone
// (RULE14) software writes 1100 into word three 11:8
// (RULE15) no cache: cache bits without function
// (RULE16) legacy start sets active flag, zero clears
// (RULE17) native: inner level if outer active
// (RULE18) protected bits read zero through alias
// (RULE19) at end: branch and decrement or finish
// (RULE20) reset loads documented status values
`timescale 1ns/1ps
`default_nettype none
module blkrp_regs #(
  parameter bit CACHE_PRESENT = 1'b1
) (
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire logic                   clkEn,
  input  wire logic                   progMemSelPin,
  input  wire blkrp_pkg::blkrp_daddr_t memAddr,
  input  wire logic                   memWrEn,
  input  wire logic                   memRdEn,
  input  wire blkrp_pkg::blkrp_word_t  memWrData,
  output logic [15:0]                 memRdData,
  output logic                        memRdValid,
  input  wire logic                   loopStartReq,
  input  wire blkrp_pkg::blkrp_paddr_t loopStartAddr,
  input  wire blkrp_pkg::blkrp_paddr_t loopEndAddr,
  input  wire logic                   fetchValid,
  input  wire blkrp_pkg::blkrp_paddr_t fetchPc,
  output logic                        loopBranch,
  output logic [23:0]                 loopTarget,
  output logic                        outerActive,
  output logic                        innerActive,
  output logic                        legacyCompatMode,
  output logic [15:0]                 statusWordZero,
  output logic [15:0]                 statusWordOne,
  output logic [15:0]                 statusWordTwo,
  output logic [15:0]                 statusWordThree
);
  import blkrp_pkg::*;

  // ****************************************
  // address decode
  // ****************************************
  function automatic blkrp_reg_t decodeReg(input blkrp_daddr_t a);
    blkrp_reg_t r;
    unique case (a)
      ADDR_ST0:      r = REG_ST0;
      ADDR_ST1:      r = REG_ST1;
      ADDR_ST2:      r = REG_ST2;
      ADDR_ST3:      r = REG_ST3;
      ADDR_ST0_ALT:  r = REG_ST0_ALT;
      ADDR_ST1_ALT:  r = REG_ST1_ALT;
      ADDR_ST3_ALT:  r = REG_ST3_ALT;
      ADDR_OCNT:     r = REG_OCNT;
      ADDR_ICNT:     r = REG_ICNT;
      ADDR_ISAVE:    r = REG_ISAVE;
      ADDR_OSTRT_HI: r = REG_OSTRT_HI; // see RULE10
      ADDR_OSTRT_LO: r = REG_OSTRT_LO; // see RULE10
      ADDR_OEND_HI:  r = REG_OEND_HI;
      ADDR_OEND_LO:  r = REG_OEND_LO;
      ADDR_ISTRT_HI: r = REG_ISTRT_HI;
      ADDR_ISTRT_LO: r = REG_ISTRT_LO;
      ADDR_IEND_HI:  r = REG_IEND_HI;
      ADDR_IEND_LO:  r = REG_IEND_LO;
      default:       r = REG_NONE;
    endcase
    return r;
  endfunction

  blkrp_reg_t sel;
  logic       wr;

  assign sel = decodeReg(memAddr);
  assign wr  = memWrEn;

  // ****************************************
  // status words
  // ****************************************
  logic [3:0][15:0] stVal;
  logic [3:0][15:0] stSet;
  logic [3:0][15:0] stClr;
  logic [3:0][15:0] stRst;
  logic [3:0]       stFullWr;
  logic [3:0]       stAliasWr;

  assign stFullWr[0]  = wr && (sel == REG_ST0);
  assign stFullWr[1]  = wr && (sel == REG_ST1);
  assign stFullWr[2]  = wr && (sel == REG_ST2);
  assign stFullWr[3]  = wr && (sel == REG_ST3);
  assign stAliasWr[0] = wr && (sel == REG_ST0_ALT);
  assign stAliasWr[1] = wr && (sel == REG_ST1_ALT);
  assign stAliasWr[2] = 1'b0;
  assign stAliasWr[3] = wr && (sel == REG_ST3_ALT);

  always_comb begin
    stRst = ST_RESET;
    stRst[3][BIT_PROG_MEM_SEL] = progMemSelPin; // see RULE20
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gStatus
      localparam logic [15:0] WMASK = (g == 3 && !CACHE_PRESENT) ?
        (ST_WR_MASK[g] & ~ST3_CACHE_BITS) : ST_WR_MASK[g]; // see RULE15
      blkrp_status_word #(
        .WR_MASK   (WMASK),
        .PROT_MASK (ST_PROT_MASK[g])
      ) uWord (
        .clk_sys          (clk_sys),
        .srst             (srst),
        .clkEn            (clkEn),
        .fullWr           (stFullWr[g]),
        .aliasWr          (stAliasWr[g]),
        .wrData           (memWrData),
        .hwSet            (stSet[g]),
        .hwClr            (stClr[g]),
        .resetVal         (stRst[g]),
        .value            (stVal[g])
      ); // see RULE11
    end
  endgenerate

  logic legacy;
  logic loopFlag;

  assign legacy   = stVal[1][BIT_LEGACY_MODE];
  assign loopFlag = stVal[1][BIT_LOOP_ACTIVE];

  // ****************************************
  // loop levels
  // ****************************************
  blkrp_level_if outerIf ();
  blkrp_level_if innerIf ();

  blkrp_loop_level #(.SAVE_PRESENT(1'b0)) uOuter (
    .clk_sys (clk_sys),
    .srst    (srst),
    .clkEn   (clkEn),
    .lv      (outerIf.level)
  );

  blkrp_loop_level #(.SAVE_PRESENT(1'b1)) uInner (
    .clk_sys (clk_sys),
    .srst    (srst),
    .clkEn   (clkEn),
    .lv      (innerIf.level)
  );

  blkrp_top_t s_q;
  blkrp_top_t s_d;
  logic       useInner;
  logic       innerHit;
  logic       outerHit;
  logic       innerZero;
  logic       outerZero;

  assign outerActive = legacy ? loopFlag : s_q.outerRun;
  assign innerActive = !legacy && s_q.innerRun; // see RULE7
  assign useInner    = !legacy && outerActive; // see RULE17
  assign innerZero   = (innerIf.count == 16'h0000);
  assign outerZero   = (outerIf.count == 16'h0000);

  assign innerHit = innerActive && fetchValid &&
                    (fetchPc == innerIf.endAddr);
  assign outerHit = outerActive && fetchValid && !innerHit &&
                    (fetchPc == outerIf.endAddr);

  // ****************************************
  // level write strobes and sequencing
  // ****************************************
  assign outerIf.wrData    = memWrData;
  assign outerIf.wrCount   = wr && (sel == REG_OCNT);
  assign outerIf.wrSave    = 1'b0;
  assign outerIf.wrStartHi = wr && (sel == REG_OSTRT_HI);
  assign outerIf.wrStartLo = wr && (sel == REG_OSTRT_LO);
  assign outerIf.wrEndHi   = wr && (sel == REG_OEND_HI);
  assign outerIf.wrEndLo   = wr && (sel == REG_OEND_LO);
  assign outerIf.launch    = loopStartReq && !useInner;
  assign outerIf.launchStart = loopStartAddr; // see RULE2
  assign outerIf.launchEnd   = loopEndAddr; // see RULE3
  assign outerIf.step      = outerHit && !outerZero; // see RULE19

  assign innerIf.wrData    = memWrData;
  assign innerIf.wrCount   = wr && (sel == REG_ICNT); // see RULE4
  assign innerIf.wrSave    = wr && (sel == REG_ISAVE);
  assign innerIf.wrStartHi = wr && (sel == REG_ISTRT_HI);
  assign innerIf.wrStartLo = wr && (sel == REG_ISTRT_LO);
  assign innerIf.wrEndHi   = wr && (sel == REG_IEND_HI);
  assign innerIf.wrEndLo   = wr && (sel == REG_IEND_LO);
  assign innerIf.launch    = loopStartReq && useInner; // see RULE6
  assign innerIf.launchStart = loopStartAddr;
  assign innerIf.launchEnd   = loopEndAddr;
  assign innerIf.step      = innerHit && !innerZero; // see RULE19

  assign loopBranch = innerIf.step || outerIf.step; // see RULE19
  assign loopTarget = innerHit ? innerIf.startAddr : outerIf.startAddr;

  // loop active flag driven by hardware in legacy mode
  always_comb begin
    stSet = '0;
    stClr = '0;
    if (legacy && outerHit && outerZero) begin
      stClr[1][BIT_LOOP_ACTIVE] = 1'b1; // see RULE16
    end
    if (legacy && loopStartReq) begin
      stSet[1][BIT_LOOP_ACTIVE] = 1'b1; // see RULE16
    end
  end

  // ****************************************
  // read path
  // ****************************************
  function automatic blkrp_word_t hiByte(input blkrp_paddr_t a);
    return {8'h00, a[23:16]};
  endfunction

  blkrp_word_t rdMux;

  always_comb begin
    unique case (sel)
      REG_ST0:      rdMux = stVal[0];
      REG_ST1:      rdMux = stVal[1];
      REG_ST2:      rdMux = stVal[2];
      REG_ST3:      rdMux = stVal[3];
      REG_ST0_ALT:  rdMux = stVal[0] & ~ST_PROT_MASK[0]; // see RULE18
      REG_ST1_ALT:  rdMux = stVal[1] & ~ST_PROT_MASK[1]; // see RULE18
      REG_ST3_ALT:  rdMux = stVal[3] & ~ST_PROT_MASK[3]; // see RULE18
      REG_OCNT:     rdMux = outerIf.count;
      REG_ICNT:     rdMux = innerIf.count;
      REG_ISAVE:    rdMux = innerIf.save;
      REG_OSTRT_HI: rdMux = hiByte(outerIf.startAddr); // see RULE9
      REG_OSTRT_LO: rdMux = outerIf.startAddr[15:0];
      REG_OEND_HI:  rdMux = hiByte(outerIf.endAddr);
      REG_OEND_LO:  rdMux = outerIf.endAddr[15:0];
      REG_ISTRT_HI: rdMux = hiByte(innerIf.startAddr);
      REG_ISTRT_LO: rdMux = innerIf.startAddr[15:0];
      REG_IEND_HI:  rdMux = hiByte(innerIf.endAddr);
      REG_IEND_LO:  rdMux = innerIf.endAddr[15:0];
      REG_NONE:     rdMux = 16'h0000;
    endcase
  end

  // ****************************************
  // loop run state and registered read
  // ****************************************
  always_comb begin
    s_d         = s_q;
    s_d.rdValid = memRdEn;
    if (memRdEn) begin
      s_d.rdData = rdMux;
    end
    if (legacy) begin
      s_d.outerRun = 1'b0;
      s_d.innerRun = 1'b0; // see RULE7
    end else begin
      if (innerHit && innerZero) begin
        s_d.innerRun = 1'b0; // see RULE19
      end
      if (outerHit && outerZero) begin
        s_d.outerRun = 1'b0; // see RULE19
      end
      if (loopStartReq && useInner) begin
        s_d.innerRun = 1'b1; // see RULE17
      end
      if (loopStartReq && !useInner) begin
        s_d.outerRun = 1'b1; // see RULE17
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  assign memRdData        = s_q.rdData;
  assign memRdValid       = s_q.rdValid;
  assign legacyCompatMode = legacy;
  assign statusWordZero   = stVal[0];
  assign statusWordOne    = stVal[1];
  assign statusWordTwo    = stVal[2];
  assign statusWordThree  = stVal[3];
endmodule
`default_nettype wire

// [tb/blkrp_regs_properties.sv]
// checker: port-level properties of the loop and status register block
`timescale 1ns/1ps
`default_nettype none
module blkrp_regs_properties #(
  parameter bit CACHE_PRESENT = 1'b1
) (
  input wire logic                    clk_sys,
  input wire logic                    srst,
  input wire logic                    clkEn,
  input wire logic                    progMemSelPin,
  input wire blkrp_pkg::blkrp_daddr_t memAddr,
  input wire logic                    memWrEn,
  input wire logic                    memRdEn,
  input wire blkrp_pkg::blkrp_word_t  memWrData,
  input wire logic [15:0]             memRdData,
  input wire logic                    memRdValid,
  input wire logic                    loopStartReq,
  input wire blkrp_pkg::blkrp_paddr_t loopStartAddr,
  input wire blkrp_pkg::blkrp_paddr_t loopEndAddr,
  input wire logic                    fetchValid,
  input wire blkrp_pkg::blkrp_paddr_t fetchPc,
  input wire logic                    loopBranch,
  input wire logic [23:0]             loopTarget,
  input wire logic                    outerActive,
  input wire logic                    innerActive,
  input wire logic                    legacyCompatMode,
  input wire logic [15:0]             statusWordZero,
  input wire logic [15:0]             statusWordOne,
  input wire logic [15:0]             statusWordTwo,
  input wire logic [15:0]             statusWordThree
);
  import blkrp_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ****************************************
  // sequences
  // ****************************************
  sequence s_read(logic [22:0] a);
    clkEn && memRdEn && memAddr == a;
  endsequence
  sequence s_write(logic [22:0] a);
    clkEn && memWrEn && memAddr == a;
  endsequence
  sequence s_start;
    clkEn && loopStartReq;
  endsequence
  // ****************************************
  // properties
  // ****************************************
  a_read_valid_pulse: assert property (clkEn && memRdEn |=> memRdValid
    ##1 (!memRdValid || $past(memRdEn))) else $error("read valid wrong");
  a_alias0_reads_zero: assert property (s_read(ADDR_ST0_ALT) |=>
    (memRdData & ST_PROT_MASK[0]) == 16'h0000) else $error("alias0 read");
  a_alias3_reads_zero: assert property (s_read(ADDR_ST3_ALT) |=>
    (memRdData & ST_PROT_MASK[3]) == 16'h0000) else $error("alias3 read");
  a_alias_keeps_prot: assert property (s_write(ADDR_ST0_ALT) |=>
    ((statusWordZero ^ $past(statusWordZero)) & ST_PROT_MASK[0]) == 16'h0000)
    else $error("alias write changed protected bit");
  a_full_write_zero: assert property (s_write(ADDR_ST0) |=>
    statusWordZero == $past(memWrData)) else $error("full write lost");
  a_legacy_no_inner: assert property (legacyCompatMode |->
    !innerActive && legacyCompatMode == statusWordOne[BIT_LEGACY_MODE])
    else $error("inner level used in legacy mode");
  a_legacy_flag_set: assert property (s_start and
    legacyCompatMode |=> statusWordOne[BIT_LOOP_ACTIVE] && outerActive)
    else $error("flag unset");
  a_native_nest_inner: assert property (s_start
    ##0 !legacyCompatMode ##0 outerActive |=> innerActive)
    else $error("nest missed");
  a_branch_on_fetch: assert property (loopBranch |->
    fetchValid && (outerActive || innerActive)) else $error("stray branch");
  a_reset_status: assert property ($fell(srst) |->
    statusWordZero == 16'h3800 && statusWordOne == 16'h2920
    && statusWordTwo == 16'h7000
    && statusWordThree == (16'h1C00 | {9'h000, progMemSelPin, 6'h00}))
    else $error("status reset value wrong");
endmodule
bind blkrp_regs blkrp_regs_properties #(.CACHE_PRESENT(CACHE_PRESENT))
  u_props (.clk_sys, .srst, .clkEn, .progMemSelPin, .memAddr, .memWrEn,
  .memRdEn, .memWrData, .memRdData, .memRdValid, .loopStartReq,
  .loopStartAddr, .loopEndAddr, .fetchValid, .fetchPc, .loopBranch,
  .loopTarget, .outerActive, .innerActive, .legacyCompatMode,
  .statusWordZero, .statusWordOne, .statusWordTwo, .statusWordThree);
`default_nettype wire

// [tb/blkrp_seq_model.sv]
// model: sequencer that starts loops, fetches and follows branches
`timescale 1ns/1ps
`default_nettype none
module blkrp_seq_model (
  input  wire logic        clk_sys,
  input  wire logic        go,
  input  wire logic        slow,
  input  wire logic [23:0] firstPc,
  input  wire logic [23:0] lastPc,
  input  wire logic [23:0] nestPc,
  input  wire logic [23:0] nestFirst,
  input  wire logic [23:0] nestLast,
  input  wire logic        loopBranch,
  input  wire logic [23:0] loopTarget,
  output logic             loopStartReq,
  output logic      [23:0] loopStartAddr,
  output logic      [23:0] loopEndAddr,
  output logic             fetchValid,
  output logic      [23:0] fetchPc,
  output logic             busy,
  output int               passes
);
  // no counter writes at all, so none near a loop end
  logic [23:0] pc = '0;
  logic [23:0] sa = '0;
  logic [23:0] ea = '0;
  // released lines show the inverse of the held value
  assign fetchPc = fetchValid ? pc : ~pc;
  assign loopStartAddr = loopStartReq ? sa : ~sa;
  assign loopEndAddr = loopStartReq ? ea : ~ea;
  initial begin
    loopStartReq = 1'b0;
    fetchValid = 1'b0;
    busy = 1'b0;
    passes = 0;
  end
  always @(posedge clk_sys) begin
    loopStartReq <= 1'b0;
    if (go && !busy) begin
      busy <= 1'b1;
      passes <= 0;
      loopStartReq <= 1'b1;
      sa <= firstPc;
      ea <= lastPc;
      pc <= firstPc;
    end else if (busy) begin
      fetchValid <= slow ? !fetchValid : 1'b1;
      if (fetchValid) begin
        if (loopBranch) begin
          passes <= passes + 1;
          pc <= loopTarget;
        end else if (pc == lastPc) begin
          busy <= 1'b0;
          fetchValid <= 1'b0;
        end else begin
          pc <= pc + 24'h000001;
        end
        if (pc == nestPc && nestPc != 24'h000000) begin
          loopStartReq <= 1'b1;
          sa <= nestFirst;
          ea <= nestLast;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [tb/blkrp_regs_tb.sv]
// testbench: register access and loop runs against the sequencer model
`timescale 1ns/1ps
`default_nettype none
module blkrp_regs_tb;
  import blkrp_pkg::*;
  logic         clk_sys = 1'b0;
  logic         srst = 1'b1;
  logic         clkEn = 1'b1;
  logic         progMemSelPin = 1'b1;
  blkrp_daddr_t memAddr = '0;
  logic         memWrEn = 1'b0;
  logic         memRdEn = 1'b0;
  blkrp_word_t  memWrData = '0;
  logic         go = 1'b0;
  logic         slow = 1'b0;
  logic [23:0]  firstPc = '0;
  logic [23:0]  lastPc = '0;
  logic [23:0]  nestPc = '0;
  logic [23:0]  nestFirst = '0;
  logic [23:0]  nestLast = '0;
  logic [15:0]  memRdData, statusWordZero, statusWordOne;
  logic [15:0]  statusWordTwo, statusWordThree;
  logic [23:0]  loopStartAddr, loopEndAddr, fetchPc, loopTarget;
  logic         memRdValid, loopStartReq, fetchValid, loopBranch;
  logic         outerActive, innerActive, legacyCompatMode, busy;
  int           passes;
  int           fails = 0;
  int           testsRun = 0;
  blkrp_regs u_dut (.clk_sys, .srst, .clkEn, .progMemSelPin, .memAddr,
    .memWrEn, .memRdEn, .memWrData, .memRdData, .memRdValid, .loopStartReq,
    .loopStartAddr, .loopEndAddr, .fetchValid, .fetchPc, .loopBranch,
    .loopTarget, .outerActive, .innerActive, .legacyCompatMode,
    .statusWordZero, .statusWordOne, .statusWordTwo, .statusWordThree);
  blkrp_seq_model u_seq (.clk_sys, .go, .slow, .firstPc, .lastPc, .nestPc,
    .nestFirst, .nestLast, .loopBranch, .loopTarget, .loopStartReq,
    .loopStartAddr, .loopEndAddr, .fetchValid, .fetchPc, .busy, .passes);
  initial begin
    forever #50 clk_sys = !clk_sys;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string what, input logic [23:0] e, g);
    testsRun++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input blkrp_daddr_t a, input blkrp_word_t d);
    @(posedge clk_sys);
    memAddr <= a;
    memWrData <= d;
    memWrEn <= 1'b1;
    @(posedge clk_sys);
    memWrEn <= 1'b0;
  endtask
  task automatic rdc(input blkrp_daddr_t a, input blkrp_word_t e);
    @(posedge clk_sys);
    memAddr <= a;
    memRdEn <= 1'b1;
    @(posedge clk_sys);
    memRdEn <= 1'b0;
    @(negedge clk_sys);
    chk("read valid", 24'h000001, {23'h000000, memRdValid});
    chk($sformatf("read %h", a), {8'h00, e}, {8'h00, memRdData});
  endtask
  task automatic runLoop(input logic [23:0] f, l, np, s, input logic sl);
    int n;
    @(posedge clk_sys);
    firstPc <= f;
    lastPc <= l;
    nestPc <= np;
    nestFirst <= s;
    nestLast <= s + 24'h000003;
    slow <= sl;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (busy === 1'b1 && n < 400);
    chk("loop finished", 24'h000000, {23'h000000, busy});
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    #(100ns * 5000);
    fails++;
    $display("watchdog expired");
    tally_and_finish();
  end
  initial begin
    blkrp_daddr_t st[4];
    blkrp_word_t  rv[4];
    blkrp_daddr_t hi[4];
    st = '{ADDR_ST0, ADDR_ST1, ADDR_ST2, ADDR_ST3};
    rv = '{16'h3800, 16'h2920, 16'h7000, 16'h1C40};
    hi = '{23'h00003C, 23'h00003E, 23'h000042, 23'h000044};
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) rdc(st[i], rv[i]);
    wr(23'h000100, 16'h5A5A);
    rdc(23'h000100, 16'h0000);
    $display("test reset and unmapped done");
    for (int i = 0; i < 4; i++) begin
      wr(hi[i], 16'hA500 | 16'(i));
      wr(hi[i] + 23'h000001, 16'h1230 | 16'(i));
      rdc(hi[i], 16'(i));
      rdc(hi[i] + 23'h000001, 16'h1230 | 16'(i));
    end
    $display("test address split done");
    wr(ADDR_ICNT, 16'hFFFF);
    rdc(ADDR_ICNT, 16'hFFFF);
    rdc(ADDR_ISAVE, 16'hFFFF);
    wr(ADDR_OCNT, 16'hFFFF);
    rdc(ADDR_OCNT, 16'hFFFF);
    $display("test counters done");
    wr(ADDR_ST0, 16'hFFFF);
    rdc(ADDR_ST0_ALT, 16'h1FFF);
    wr(ADDR_ST0_ALT, 16'h0000);
    rdc(ADDR_ST0, 16'hE000);
    wr(ADDR_ST3, 16'hFCFF);
    rdc(ADDR_ST3_ALT, 16'h0C57);
    wr(ADDR_ST3_ALT, 16'h0C00);
    rdc(ADDR_ST3, 16'hFCA0);
    wr(ADDR_ST2, 16'h0000);
    rdc(ADDR_ST2, 16'h6000);
    $display("test status alias done");
    wr(ADDR_OCNT, 16'h0002);
    runLoop(24'h000100, 24'h000104, 24'h0, 24'h0, 1'b1);
    chk("legacy passes", 24'h000002, 24'(passes));
    rdc(ADDR_OCNT, 16'h0000);
    @(posedge clk_sys) clkEn <= 1'b0;
    wr(ADDR_OCNT, 16'h1234);
    clkEn <= 1'b1;
    rdc(ADDR_OCNT, 16'h0000);
    chk("loop flag", 24'h000000, {23'h0, statusWordOne[15]});
    $display("test legacy loop done");
    wr(ADDR_ST1, 16'h2900);
    @(negedge clk_sys);
    chk("mode", 24'h000000, {23'h0, legacyCompatMode});
    wr(ADDR_ICNT, 16'h0002);
    wr(ADDR_OCNT, 16'h0001);
    runLoop(24'h000100, 24'h00010F, 24'h000103, 24'h000104, 1'b0);
    chk("nested passes", 24'h000005, 24'(passes));
    rdc(ADDR_ISAVE, 16'h0002);
    rdc(ADDR_ICNT, 16'h0000);
    $display("test nested loop done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
